// ---- rtl/smb_pkg.sv ----
// Constants, encodings and command type of the mode and burst block
package smb_pkg;
    // Configuration word layout
    localparam int MODE_W = 13;
    localparam int BL_LSB = 0;
    localparam int BL_W = 3;
    localparam int ORDER_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int LAT_W = 3;
    localparam int OPMODE_LSB = 7;
    localparam int OPMODE_W = 2;
    localparam int SWR_BIT = 9;
    localparam int RSV_LSB = 10;
    localparam int RSV_W = 3;
    localparam logic [MODE_W-1:0] MODE_RST = 13'h0000;

    // Burst length codes
    localparam logic [BL_W-1:0] BL_1 = 3'h0;
    localparam logic [BL_W-1:0] BL_2 = 3'h1;
    localparam logic [BL_W-1:0] BL_4 = 3'h2;
    localparam logic [BL_W-1:0] BL_8 = 3'h3;
    localparam logic [BL_W-1:0] BL_PAGE = 3'h7;

    // Read latency codes
    localparam logic [LAT_W-1:0] LAT_2 = 3'h2;
    localparam logic [LAT_W-1:0] LAT_3 = 3'h3;

    // Precharge-all select bit on the address
    localparam int PRE_ALL_BIT = 10;

    // Least spacing of activates to different banks, in cycles
    localparam int RRD_CYC = 2;

    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_MODE,
        CMD_ACT,
        CMD_READ,
        CMD_WRITE,
        CMD_STOP,
        CMD_PRE
    } smb_cmd_e;
endpackage : smb_pkg

// ---- rtl/smb_beat_if.sv ----
// Valid/ready carrier for column beats between the sequencer and buffer
`timescale 1ns/10ps
interface smb_beat_if #(parameter int W = 12) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : smb_beat_if

// ---- rtl/smb_skid.sv ----
// Two-entry registered buffer in the column beat path
`timescale 1ns/10ps
module smb_skid #(
    parameter int W = 12,
    parameter int DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic reset_n,
    smb_beat_if.snk up,
    smb_beat_if.src dn
);
    generate
        if (DEPTH != 2 || W < 1) begin : g_bad_cfg
            $error("smb_skid supports only DEPTH 2 and W of 1 or more");
        end
    endgenerate

    logic out_valid_q;
    logic [W-1:0] out_data_q;
    logic skid_valid_q;
    logic [W-1:0] skid_data_q;
    wire logic take = up.valid & ~skid_valid_q;
    wire logic drain = dn.ready | ~out_valid_q;

    // Ready from a flop keeps the upstream path short
    assign up.ready = ~skid_valid_q;
    assign dn.valid = out_valid_q;
    assign dn.data = out_data_q;

    // Skid entry catches the word landing during a stall
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
            skid_valid_q <= 1'b0;
            skid_data_q <= '0;
        end else if (drain) begin
            if (skid_valid_q) begin
                out_valid_q <= 1'b1;
                out_data_q <= skid_data_q;
                skid_valid_q <= 1'b0;
            end else begin
                out_valid_q <= take;
                out_data_q <= up.data;
            end
        end else if (take) begin
            skid_valid_q <= 1'b1;
            skid_data_q <= up.data;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_skid_hold: assert property (
        dn.valid & ~dn.ready |=> dn.valid && $stable(dn.data))
        else $error("buffer output changed while stalled");
endmodule : smb_skid

// ---- rtl/smb_top.sv ----
// Mode word, burst column sequencing, read latency and bank activation
// Functional notes
// [RULE_01] Configuration word holds its value until the next mode-load command.
// [RULE_02] Word: bits 0-2 length, 3 order, 4-6 latency, 7-8 mode, 9 writes.
// [RULE_03] Controller loads the word only with all banks idle, then waits.
// [RULE_04] Lengths 1, 2, 4, 8 both orders; whole page only sequential.
// [RULE_05] Whole-page burst runs until burst stop, wrapping inside the page.
// [RULE_06] Upper column bits pick an aligned block; lower bits give start.
// [RULE_07] Bit 3 picks sequential or interleaved order for bursts of length 1 to 8.
// [RULE_08] Sequential adds the count modulo length; interleaved XORs it.
// [RULE_09] Read latency is two or three cycles only.
// [RULE_10] Read at edge n, latency m: drive from n+m-1, valid by n+m.
// [RULE_11] Controller keeps the clock within the limit for its latency.
// [RULE_12] Controller avoids reserved length and latency codes.
// [RULE_13] Normal operation needs both mode bits 7 and 8 at zero.
// [RULE_14] Bit 9 set: reads burst, each write touches one location.
// [RULE_15] Controller activates a row in a bank before reading or writing.
// [RULE_16] Controller rounds activate-to-column time up to whole cycles.
// [RULE_17] Controller precharges before another row, spaces same-bank activates.
// [RULE_18] Activate to another bank allowed; bank-to-bank spacing applies.
// [RULE_19] Controller waits two cycles after a mode-load command.
// [RULE_20] Activate to column is three cycles at latency three, two at two.
// [RULE_21] Activates to different banks are at least two cycles apart.
// [RULE_22] Word is unknown after power-up; load it before operating.
// [RULE_23] Length codes 0/1/2/3/7, order 0 sequential, latency codes 2/3.
`timescale 1ns/10ps
module smb_top #(
    parameter int COL_W = 9,
    parameter int ROW_W = 13,
    parameter int BANK_W = 2
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire smb_pkg::smb_cmd_e cmd,
    input wire logic [BANK_W-1:0] cmd_bank,
    input wire logic [ROW_W-1:0] cmd_addr,
    input wire logic beat_ready,
    output logic beat_valid,
    output logic beat_write,
    output logic [BANK_W-1:0] beat_bank,
    output logic [COL_W-1:0] beat_col,
    output logic dq_drive,
    output logic rd_data_valid,
    output logic [smb_pkg::MODE_W-1:0] mode_word,
    output logic cfg_loaded,
    output logic cfg_reserved,
    output logic cmd_err,
    output logic act_err,
    output logic [(1<<BANK_W)-1:0] bank_open
);
    localparam int NBANK = 1 << BANK_W;
    localparam int BW = 1 + BANK_W + COL_W;

    generate
        if (COL_W < 4 || COL_W >= ROW_W || ROW_W < smb_pkg::MODE_W ||
            ROW_W <= smb_pkg::PRE_ALL_BIT || BANK_W < 1) begin : g_bad_cfg
            $error("smb_top address widths cannot be served");
        end
    endgenerate

    // Column mask of a burst length code; reserved codes act as length one
    function automatic logic [COL_W-1:0] bl_mask(
        input logic [smb_pkg::BL_W-1:0] code);
        logic [COL_W-1:0] m;
        m = '0;
        unique case (code)
            smb_pkg::BL_2: m = COL_W'(1);
            smb_pkg::BL_4: m = COL_W'(3);
            smb_pkg::BL_8: m = COL_W'(7);
            smb_pkg::BL_PAGE: m = '1;
            default: m = '0;
        endcase
        return m;
    endfunction : bl_mask

    // Column of beat k: block kept, low bits stepped or XORed
    function automatic logic [COL_W-1:0] beat_col_of(
        input logic [COL_W-1:0] start,
        input logic [COL_W-1:0] k,
        input logic [COL_W-1:0] mask,
        input logic inter);
        logic [COL_W-1:0] low;
        low = inter ? (start ^ k) : COL_W'(start + k);
        return (start & ~mask) | (low & mask);
    endfunction : beat_col_of

    // Reserved length, latency, mode or page-interleave combination
    function automatic logic word_bad(input logic [smb_pkg::MODE_W-1:0] w);
        logic [smb_pkg::BL_W-1:0] bl;
        logic [smb_pkg::LAT_W-1:0] lt;
        bl = w[smb_pkg::BL_LSB +: smb_pkg::BL_W];
        lt = w[smb_pkg::LAT_LSB +: smb_pkg::LAT_W];
        return (bl > smb_pkg::BL_8 && bl != smb_pkg::BL_PAGE) ||
            (bl == smb_pkg::BL_PAGE && w[smb_pkg::ORDER_BIT]) ||
            (lt != smb_pkg::LAT_2 && lt != smb_pkg::LAT_3) ||
            (w[smb_pkg::OPMODE_LSB +: smb_pkg::OPMODE_W] != '0);
    endfunction : word_bad

    logic [smb_pkg::MODE_W-1:0] mode_q;
    logic loaded_q;
    logic reserved_q;
    logic busy_q;
    logic wr_q;
    logic [BANK_W-1:0] bank_q;
    logic [COL_W-1:0] start_q;
    logic [COL_W-1:0] k_q;
    logic [2:0] rd_pipe_q;
    logic drive_q;
    logic rvalid_q;
    logic cmd_err_q;
    logic act_err_q;
    logic act_seen_q;
    logic [1:0] gap_q;
    logic [BANK_W-1:0] last_act_q;
    logic [NBANK-1:0] open_q;
    logic [ROW_W-1:0] row_q [NBANK];

    // Command decode
    wire logic is_mode = (cmd == smb_pkg::CMD_MODE);
    wire logic is_act = (cmd == smb_pkg::CMD_ACT);
    wire logic is_rd = (cmd == smb_pkg::CMD_READ);
    wire logic is_wr = (cmd == smb_pkg::CMD_WRITE);
    wire logic is_stop = (cmd == smb_pkg::CMD_STOP);
    wire logic is_pre = (cmd == smb_pkg::CMD_PRE);
    wire logic rw_cmd = is_rd | is_wr;
    wire logic rw_ok = rw_cmd & loaded_q & open_q[cmd_bank]; // RULE_22

    // Fields of the held word
    wire logic [smb_pkg::BL_W-1:0] burst_length_field =
        mode_q[smb_pkg::BL_LSB +: smb_pkg::BL_W];
    wire logic burst_order_bit = mode_q[smb_pkg::ORDER_BIT];
    wire logic [smb_pkg::LAT_W-1:0] read_latency_field =
        mode_q[smb_pkg::LAT_LSB +: smb_pkg::LAT_W];
    wire logic single_write_select_bit = mode_q[smb_pkg::SWR_BIT];
    wire logic page = (burst_length_field == smb_pkg::BL_PAGE); // RULE_23
    // Page with interleave is unsupported, so it runs sequential
    wire logic inter = burst_order_bit & ~page; // RULE_04 RULE_07
    // Reserved latency codes fall back to two
    wire logic lat3 = (read_latency_field == smb_pkg::LAT_3); // RULE_09

    // Beat source: a fresh command wins over a running burst
    wire logic src_wr = rw_ok ? is_wr : wr_q;
    wire logic [BANK_W-1:0] src_bank = rw_ok ? cmd_bank : bank_q;
    wire logic [COL_W-1:0] src_start = rw_ok ? cmd_addr[COL_W-1:0] : start_q;
    wire logic [COL_W-1:0] src_k = rw_ok ? '0 : k_q;
    wire logic one_wr = src_wr & single_write_select_bit; // RULE_14
    wire logic [COL_W-1:0] src_mask =
        one_wr ? '0 : bl_mask(burst_length_field); // RULE_06
    wire logic src_page = page & ~one_wr;
    wire logic [COL_W-1:0] src_col =
        beat_col_of(src_start, src_k, src_mask, inter); // RULE_08
    // A stop takes effect at its own edge: no beat is issued with it
    wire logic src_valid = rw_ok | (busy_q & ~is_stop); // RULE_05
    wire logic last = ~src_page & (src_k == src_mask); // RULE_05
    wire logic [COL_W-1:0] k_next = COL_W'(src_k + 1'b1);

    smb_beat_if #(.W(BW)) up_if ();
    smb_beat_if #(.W(BW)) dn_if ();

    assign up_if.valid = src_valid;
    assign up_if.data = {src_wr, src_bank, src_col};
    assign dn_if.ready = beat_ready;
    wire logic accept = src_valid & up_if.ready;
    wire logic rd_beat = accept & ~src_wr;

    smb_skid #(.W(BW), .DEPTH(2)) u_skid (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .up(up_if.snk),
        .dn(dn_if.src)
    );

    // Word changes only on a mode-load command
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mode_q <= smb_pkg::MODE_RST;
            loaded_q <= 1'b0;
            reserved_q <= 1'b0;
        end else if (is_mode) begin
            mode_q <= cmd_addr[smb_pkg::MODE_W-1:0]; // RULE_01 RULE_02
            loaded_q <= 1'b1; // RULE_22
            reserved_q <= word_bad(cmd_addr[smb_pkg::MODE_W-1:0]); // RULE_13
        end
    end

    // Burst sequencer; a stalled buffer holds the count
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            wr_q <= 1'b0;
            bank_q <= '0;
            start_q <= '0;
            k_q <= '0;
        end else if (rw_ok) begin
            // New command truncates any running burst
            wr_q <= is_wr;
            bank_q <= cmd_bank;
            start_q <= cmd_addr[COL_W-1:0];
            k_q <= accept ? k_next : '0;
            busy_q <= ~(accept & last); // RULE_14
        end else if (is_stop) begin
            busy_q <= 1'b0; // RULE_05
        end else if (accept) begin
            busy_q <= ~last;
            k_q <= k_next;
        end
    end

    // Read beats walk a delay line; latency picks the tap
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rd_pipe_q <= '0;
            drive_q <= 1'b0;
            rvalid_q <= 1'b0;
        end else begin
            rd_pipe_q <= {rd_pipe_q[1:0], rd_beat};
            drive_q <= lat3 ? rd_pipe_q[1] : rd_pipe_q[0]; // RULE_10
            rvalid_q <= lat3 ? rd_pipe_q[2] : rd_pipe_q[1]; // RULE_10
        end
    end

    // Spacing count since the last activate, saturating
    wire logic act_other = act_seen_q & (cmd_bank != last_act_q);
    wire logic act_close = act_other & (gap_q < 2'(smb_pkg::RRD_CYC - 1));
    wire logic act_bad = is_act & (act_close | open_q[cmd_bank]);

    // Activation tracking; a violating activate is still taken
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            open_q <= '0;
            act_seen_q <= 1'b0;
            gap_q <= '0;
            last_act_q <= '0;
            act_err_q <= 1'b0;
            cmd_err_q <= 1'b0;
        end else begin
            act_err_q <= act_bad; // RULE_18
            cmd_err_q <= rw_cmd & ~rw_ok; // RULE_15
            if (is_act) begin
                open_q[cmd_bank] <= 1'b1;
                act_seen_q <= 1'b1;
                last_act_q <= cmd_bank;
                gap_q <= '0;
            end else begin
                if (gap_q != 2'(smb_pkg::RRD_CYC - 1)) begin
                    gap_q <= 2'(gap_q + 1'b1);
                end
                if (is_pre && cmd_addr[smb_pkg::PRE_ALL_BIT]) begin
                    open_q <= '0; // RULE_17
                end else if (is_pre) begin
                    open_q[cmd_bank] <= 1'b0;
                end
            end
        end
    end

    // Open row per bank, no reset needed for data
    always_ff @(posedge core_clk) begin
        if (is_act) begin
            row_q[cmd_bank] <= cmd_addr;
        end
    end

    // Outputs, all from flops
    assign beat_valid = dn_if.valid;
    assign {beat_write, beat_bank, beat_col} = dn_if.data;
    assign dq_drive = drive_q;
    assign rd_data_valid = rvalid_q;
    assign mode_word = mode_q;
    assign cfg_loaded = loaded_q;
    assign cfg_reserved = reserved_q;
    assign cmd_err = cmd_err_q;
    assign act_err = act_err_q;
    assign bank_open = open_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_mode_hold: assert property ( // RULE_01
        !is_mode |=> $stable(mode_q))
        else $error("mode word changed without a load");
    a_mode_fields: assert property ( // RULE_02
        is_mode |=> burst_length_field == $past(cmd_addr[2:0]) &&
            read_latency_field == $past(cmd_addr[6:4]) &&
            single_write_select_bit == $past(cmd_addr[9]))
        else $error("mode fields misplaced");
    a_block_kept: assert property ( // RULE_06
        accept |-> (src_col & ~src_mask) == (src_start & ~src_mask))
        else $error("burst left its block");
    a_interleave_low: assert property ( // RULE_08
        accept && inter |-> (src_col & src_mask) == ((src_start ^ src_k)
            & src_mask))
        else $error("interleaved order wrong");
    a_page_sequential: assert property ( // RULE_04
        accept && page && !one_wr |-> src_col == COL_W'(src_start + src_k))
        else $error("page burst not sequential");
    a_page_runs: assert property ( // RULE_05
        busy_q && page && !wr_q && !rw_cmd && !is_stop |=> busy_q)
        else $error("page burst ended without stop");
    a_single_write: assert property ( // RULE_14
        accept && one_wr |=> !busy_q)
        else $error("single write burst ran on");
    a_lat_two: assert property ( // RULE_10
        rd_beat && !lat3 && !is_mode |-> ##1 !is_mode ##1 dq_drive ##1
            rd_data_valid)
        else $error("latency two timing wrong");
    a_lat_three: assert property ( // RULE_10
        rd_beat && lat3 && !is_mode ##1 !is_mode[*2] |-> ##1 dq_drive ##1
            rd_data_valid)
        else $error("latency three timing wrong");
    a_act_spacing: assert property ( // RULE_18
        is_act && act_seen_q && cmd_bank != last_act_q &&
            $past(is_act) |=> act_err)
        else $error("close activates not flagged");
    a_unloaded_rw: assert property ( // RULE_22
        rw_cmd && !loaded_q |=> cmd_err)
        else $error("access before load not flagged");
    a_row_kept: assert property ( // RULE_15
        is_act |=> row_q[$past(cmd_bank)] == $past(cmd_addr))
        else $error("open row not recorded");
endmodule : smb_top

// ---- sim/smb_ctrl_model.sv ----
// Command-issuing controller model facing the mode and burst block
`timescale 1ns/10ps
module smb_ctrl_model (
    input wire logic core_clk,
    output smb_pkg::smb_cmd_e cmd,
    output logic [1:0] cmd_bank,
    output logic [12:0] cmd_addr,
    output logic beat_ready
);
    // Quiet command bus and a willing receiver from time zero
    initial begin
        cmd = smb_pkg::CMD_NOP;
        cmd_bank = 2'h0;
        cmd_addr = 13'h0000;
        beat_ready = 1'b1;
    end

    // One command per edge; a 20 MHz clock suits either latency
    task automatic issue(input smb_pkg::smb_cmd_e c, input logic [1:0] b,
                         input logic [12:0] a);
        @(posedge core_clk);
        cmd <= c;
        cmd_bank <= b;
        cmd_addr <= a;
    endtask : issue

    task automatic nop(input int n);
        repeat (n) issue(smb_pkg::CMD_NOP, 2'h0, 13'h0000);
    endtask : nop

    // Banks closed before a load, idle cycles after it
    task automatic load(input logic [12:0] w);
        issue(smb_pkg::CMD_PRE, 2'h0, 13'h0400);
        nop(3);
        issue(smb_pkg::CMD_MODE, 2'h0, w);
        nop(2);
    endtask : load

    // Three idle cycles cover the column delay at either latency
    task automatic act_row(input logic [1:0] b, input logic [12:0] r);
        issue(smb_pkg::CMD_ACT, b, r);
        nop(3);
    endtask : act_row

    task automatic set_ready(input logic v);
        @(posedge core_clk);
        beat_ready <= v;
    endtask : set_ready
endmodule : smb_ctrl_model

// ---- sim/sdram_mode_burst_activation_tb.sv ----
// Self-checking bench for the mode word, burst order and activation block
`timescale 1ns/10ps
`define CHK(s_, e_, a_) begin checks_done++; if ((a_) !== (e_)) begin \
    fail_count++; $display("ERROR %s exp %0h got %0h", s_, e_, a_); end end
module sdram_mode_burst_activation_tb;
    logic core_clk, reset_n;
    smb_pkg::smb_cmd_e cmd;
    logic [1:0] cmd_bank, beat_bank;
    logic [12:0] cmd_addr, mode_word;
    logic beat_ready, beat_valid, beat_write, dq_drive, rd_data_valid;
    logic cfg_loaded, cfg_reserved, cmd_err, act_err;
    logic [8:0] beat_col;
    logic [3:0] bank_open;
    logic [11:0] seen[$];
    int fail_count = 0;
    int checks_done = 0;

    smb_top u_smb_top (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .cmd(cmd),
        .cmd_bank(cmd_bank),
        .cmd_addr(cmd_addr),
        .beat_ready(beat_ready),
        .beat_valid(beat_valid),
        .beat_write(beat_write),
        .beat_bank(beat_bank),
        .beat_col(beat_col),
        .dq_drive(dq_drive),
        .rd_data_valid(rd_data_valid),
        .mode_word(mode_word),
        .cfg_loaded(cfg_loaded),
        .cfg_reserved(cfg_reserved),
        .cmd_err(cmd_err),
        .act_err(act_err),
        .bank_open(bank_open)
    );
    smb_ctrl_model u_ctrl (
        .core_clk(core_clk),
        .cmd(cmd),
        .cmd_bank(cmd_bank),
        .cmd_addr(cmd_addr),
        .beat_ready(beat_ready)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Only beats the receiver really took; bank and write above the column
    always @(posedge core_clk) begin
        if (beat_valid === 1'b1 && beat_ready === 1'b1) begin
            seen.push_back({beat_bank, beat_write, beat_col});
        end
    end

    // Column of beat k: aligned block kept, low bits stepped or XORed
    function automatic logic [8:0] exp_col(input logic [8:0] s, input int k,
                                           input int len, input bit il);
        logic [8:0] m;
        m = 9'(len - 1);
        exp_col = il ? ((s & ~m) | ((s & m) ^ 9'(k)))
                     : ((s & ~m) | ((s + 9'(k)) & m));
    endfunction : exp_col

    // Load, open bank zero, run one burst; optional stall or early stop
    task automatic burst(input logic [12:0] w, input bit wr,
                         input logic [8:0] s, input int len, input bit il,
                         input int n, input bit stall, input bit stp);
        seen.delete();
        u_ctrl.load(w);
        `CHK("mode_word", w, mode_word)
        u_ctrl.act_row(2'h0, 13'h0123);
        if (stall) begin
            u_ctrl.set_ready(1'b0);
        end
        u_ctrl.issue(wr ? smb_pkg::CMD_WRITE : smb_pkg::CMD_READ, 2'h0,
                     {4'h0, s});
        u_ctrl.nop(3);
        u_ctrl.issue(stp ? smb_pkg::CMD_STOP : smb_pkg::CMD_NOP, 2'h0,
                     13'h0000);
        u_ctrl.nop(2);
        u_ctrl.set_ready(1'b1);
        u_ctrl.nop(14);
        `CHK("beats", n, seen.size())
        for (int k = 0; k < n; k++) begin
            `CHK("beat", {2'h0, wr, exp_col(s, k, len, il)}, seen[k])
        end
        `CHK("held_word", w, mode_word)
    endtask : burst

    // Cycles from the read's edge to drive and to valid data
    task automatic latency(input logic [12:0] w, input int m);
        int n, nd, nv;
        n = 0;
        nd = 0;
        nv = 0;
        u_ctrl.load(w);
        u_ctrl.act_row(2'h1, 13'h0001);
        u_ctrl.issue(smb_pkg::CMD_READ, 2'h1, 13'h0004);
        while (nv == 0 && n < 10) begin
            u_ctrl.nop(1);
            #1;
            n++;
            if (dq_drive === 1'b1 && nd == 0) nd = n;
            if (rd_data_valid === 1'b1) nv = n;
        end
        `CHK("drive_at", m, nd)
        `CHK("valid_at", m + 1, nv)
        `CHK("read_beat", {2'h1, 1'b0, 9'h004}, seen[$])
        u_ctrl.nop(8);
    endtask : latency

    task automatic tally_and_finish();
        if (fail_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // Generous bound; the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        reset_n = 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        #1;
        `CHK("reset_word", 13'h0000, mode_word)
        `CHK("reset_loaded", 1'b0, cfg_loaded)
        u_ctrl.issue(smb_pkg::CMD_READ, 2'h0, 13'h0000);
        u_ctrl.nop(1);
        #1;
        `CHK("early_read", 1'b1, cmd_err)
        u_ctrl.load(13'h0022);
        `CHK("loaded", 1'b1, cfg_loaded)
        u_ctrl.issue(smb_pkg::CMD_READ, 2'h3, 13'h0000);
        u_ctrl.nop(1);
        #1;
        `CHK("closed_read", 1'b1, cmd_err)
        // Activates one cycle apart, two apart, then to an open bank
        u_ctrl.issue(smb_pkg::CMD_ACT, 2'h0, 13'h0010);
        u_ctrl.issue(smb_pkg::CMD_ACT, 2'h1, 13'h0011);
        u_ctrl.nop(1);
        #1;
        `CHK("act_close", 1'b1, act_err)
        u_ctrl.issue(smb_pkg::CMD_ACT, 2'h2, 13'h0012);
        u_ctrl.nop(1);
        #1;
        `CHK("act_spaced", 1'b0, act_err)
        u_ctrl.issue(smb_pkg::CMD_ACT, 2'h0, 13'h0013);
        u_ctrl.nop(1);
        #1;
        `CHK("act_open", 1'b1, act_err)
        `CHK("banks", 4'h7, bank_open)
        u_ctrl.issue(smb_pkg::CMD_PRE, 2'h1, 13'h0000);
        u_ctrl.nop(1);
        #1;
        `CHK("pre_one", 4'h5, bank_open)
        burst(13'h0022, 0, 9'h005, 4, 0, 4, 0, 0);
        burst(13'h002a, 0, 9'h001, 4, 1, 4, 0, 0);
        burst(13'h002b, 0, 9'h00d, 8, 1, 8, 1, 0);
        burst(13'h0021, 0, 9'h007, 2, 0, 2, 0, 0);
        burst(13'h0020, 0, 9'h0a3, 1, 0, 1, 0, 0);
        burst(13'h0022, 1, 9'h006, 4, 0, 4, 0, 0);
        burst(13'h0222, 1, 9'h006, 4, 0, 1, 0, 0);
        burst(13'h0222, 0, 9'h006, 4, 0, 4, 0, 0);
        burst(13'h0027, 0, 9'h1fe, 512, 0, 4, 0, 1);
        burst(13'h002f, 0, 9'h1fe, 512, 0, 4, 0, 1);
        latency(13'h0020, 2);
        latency(13'h0050, 2);
        `CHK("lat_reserved", 1'b1, cfg_reserved)
        latency(13'h0030, 3);
        `CHK("normal", 1'b0, cfg_reserved)
        u_ctrl.load(13'h01a2);
        `CHK("test_mode", 1'b1, cfg_reserved)
        tally_and_finish();
    end
endmodule : sdram_mode_burst_activation_tb
